// ---- rtl/sfab_pkg.sv ----
// Package: system fabric address map, flash port and timing constants
package sfab_pkg;

	// ==========================================
	// Address map
	localparam logic [31:0] ROM_HI = 32'h0003_FFFF;
	localparam logic [31:0] FLASH_LO = 32'h1000_0000;
	localparam logic [31:0] FLASH_HI = 32'h100F_FFFF;
	localparam logic [31:0] SRAM_LO = 32'h2000_0000;
	localparam logic [31:0] SRAM_HI = 32'h2001_7FFF;
	localparam logic [31:0] LINK_LO = 32'h3000_0000;
	localparam logic [31:0] LINK_HI = 32'h3000_FFFF;
	localparam logic [31:0] PER0_LO = 32'h4000_0000;
	localparam logic [31:0] PER0_HI = 32'h4000_FFFF;
	localparam logic [31:0] GPIO_LO = 32'h4001_0000;
	localparam logic [31:0] GPIO_HI = 32'h4001_1FFF;
	localparam logic [31:0] SYSC_LO = 32'h4001_F000;
	localparam logic [31:0] SYSC_HI = 32'h4001_FFFF;
	localparam logic [31:0] PER1_LO = 32'h5000_0000;
	localparam logic [31:0] PER1_HI = 32'h5000_FFFF;
	localparam logic [31:0] OTP_LO = 32'h6000_0000;
	localparam logic [31:0] OTP_HI = 32'h6000_0FFF;
	localparam logic [31:0] DMA_LO = 32'h7000_0000;
	localparam logic [31:0] DMA_HI = 32'h7000_0FFF;
	localparam logic [31:0] MIC_LO = 32'h8000_0000;
	localparam logic [31:0] MIC_HI = 32'h8000_0FFF;

	// Slave regions first so the enum indexes the select vector
	typedef enum logic [3:0] {
		REGION_ROM, REGION_SRAM, REGION_LINK, REGION_FIRST_PERIPH, REGION_GPIO,
		REGION_SYSTEM_CONTROL_BLOCK, REGION_SECOND_PERIPH, REGION_ONE_TIME_PROG,
		REGION_DMA, REGION_DIGITAL_MIC, REGION_FLASH, REGION_NONE
	} sfab_region_e;
	localparam int NUM_SLV = 10;

	// ==========================================
	// RAM banks
	localparam int NUM_BANKS = 8;
	localparam int BANK_LSB = 14;
	localparam int BANK_W = 3;
	localparam logic [7:0] LINK_BANKS = 8'hC0;
	typedef enum logic [1:0] {LP_ACTIVE, LP_RETENTION, LP_HIBERNATE} sfab_lp_e;

	// ==========================================
	// Flash port
	localparam int SYS_CLK_MHZ = 100;
	localparam int SCK_MAX_MHZ = 32;
	localparam int SCK_HALF_CYC = (SYS_CLK_MHZ + 2 * SCK_MAX_MHZ - 1) / (2 * SCK_MAX_MHZ);
	localparam logic [7:0] CMD_QREAD = 8'hEB;
	localparam logic [7:0] CMD_READ = 8'h03;
	localparam logic [7:0] CMD_PROG = 8'h02;
	localparam logic [5:0] BITS_CMD_ADDR = 6'h20;
	localparam logic [5:0] BITS_BYTE = 6'h08;
	localparam logic [5:0] BITS_WORD = 6'h20;
	localparam int CACHE_IDX_W = 4;
	localparam int CACHE_LINES = 16;
	localparam int FL_ADDR_W = 20;
	localparam int OUT_W = 40;

endpackage

// ---- rtl/sfab_qspi_phy.sv ----
// Serial flash shifter: one or four lanes, out phase then in phase
`timescale 1ns/1ps
module sfab_qspi_phy (
	input wire logic i_clk,
	input wire logic i_reset,
	input wire logic i_start,
	input wire logic i_quad,
	input wire logic [5:0] i_out_bits,
	input wire logic [39:0] i_out_data,
	input wire logic [5:0] i_in_bits,
	input wire logic [3:0] i_dq,
	output logic o_busy,
	output logic o_done,
	output logic [31:0] o_in_data,
	output logic o_sck,
	output logic o_cs_n,
	output logic [3:0] o_dq,
	output logic [3:0] o_dq_oe_n
);
	typedef enum logic [1:0] {P_IDLE, P_OUT, P_IN, P_END} sfab_phy_e;
	sfab_phy_e state_q;
	logic [7:0] div_q;
	logic tick;
	logic [39:0] sr_q;
	logic [5:0] out_q, in_q, step;
	logic [3:0] s1_q, s2_q, s3_q, dq_f_q;

	// Flash clock rate enable, kept apart from the system rate
	assign tick = (div_q == 8'(sfab_pkg::SCK_HALF_CYC - 1));
	assign step = i_quad ? 6'h04 : 6'h01;
	assign o_busy = (state_q != P_IDLE);
	assign o_dq = i_quad ? sr_q[39:36] : {3'h0, sr_q[39]};

	always_ff @(posedge i_clk) begin
		if (i_reset || state_q == P_IDLE || tick) div_q <= 8'h00;
		else div_q <= div_q + 8'h01;
	end

	// Pin filter: a lane changes once stages two and three agree
	always_ff @(posedge i_clk) begin
		s1_q <= i_dq;
		s2_q <= s1_q;
		s3_q <= s2_q;
		dq_f_q <= (s3_q & ~(s2_q ^ s3_q)) | (dq_f_q & (s2_q ^ s3_q));
	end

	always_ff @(posedge i_clk) begin
		o_done <= 1'b0;
		if (i_reset) begin
			state_q <= P_IDLE;
			o_sck <= 1'b0;
			o_cs_n <= 1'b1;
			o_dq_oe_n <= 4'hF;
			sr_q <= '0;
			out_q <= '0;
			in_q <= '0;
			o_in_data <= '0;
		end else begin
			case (state_q)
				P_IDLE: if (i_start) begin
					sr_q <= i_out_data;
					out_q <= i_out_bits;
					in_q <= i_in_bits + step;
					o_cs_n <= 1'b0;
					o_in_data <= '0;
					o_dq_oe_n <= i_quad ? 4'h0 : 4'hE;
					state_q <= (i_out_bits != 6'h00) ? P_OUT : P_IN;
				end
				P_OUT: if (tick) begin
					o_sck <= ~o_sck;
					if (o_sck) begin
						sr_q <= i_quad ? {sr_q[35:0], 4'h0} : {sr_q[38:0], 1'b0};
						out_q <= out_q - step;
						if (out_q == step) begin
							o_dq_oe_n <= 4'hF;
							state_q <= (in_q == step) ? P_END : P_IN;
						end
					end
				end
				P_IN: if (tick) begin
					o_sck <= ~o_sck;
					if (!o_sck) begin
						// Spare first rise: filter still holds turnaround data
						if (in_q != i_in_bits + step)
							o_in_data <= i_quad ? {o_in_data[27:0], dq_f_q} : {o_in_data[30:0], dq_f_q[1]};
						in_q <= in_q - step;
					end else if (in_q == 6'h00) begin
						state_q <= P_END;
					end
				end
				P_END: begin
					o_cs_n <= 1'b1;
					o_done <= 1'b1;
					state_q <= P_IDLE;
				end
				default: state_q <= P_IDLE;
			endcase
		end
	end
endmodule

// ---- rtl/sfab_dma.sv ----
// Memory copy and constant fill engine, master on the fabric
`timescale 1ns/1ps
module sfab_dma (
	input wire logic i_clk,
	input wire logic i_reset,
	input wire logic i_go,
	input wire logic i_fill,
	input wire logic [31:0] i_src,
	input wire logic [31:0] i_dst,
	input wire logic [15:0] i_words,
	input wire logic [31:0] i_fill_val,
	output logic o_req,
	output logic [31:0] o_addr,
	output logic o_write,
	output logic [31:0] o_wdata,
	input wire logic i_ack,
	input wire logic [31:0] i_rdata,
	output logic o_busy,
	output logic o_done
);
	typedef enum logic [1:0] {D_IDLE, D_RD, D_WR} sfab_dma_e;
	sfab_dma_e state_q;
	logic [31:0] src_q, dst_q;
	logic [15:0] left_q;

	assign o_busy = (state_q != D_IDLE);
	assign o_req = o_busy;
	assign o_write = (state_q == D_WR);
	assign o_addr = o_write ? dst_q : src_q;

	always_ff @(posedge i_clk) begin
		o_done <= 1'b0;
		if (i_reset) begin
			state_q <= D_IDLE;
			src_q <= '0;
			dst_q <= '0;
			left_q <= '0;
			o_wdata <= '0;
		end else begin
			case (state_q)
				D_IDLE: if (i_go && i_words != 16'h0000) begin
					src_q <= i_src;
					dst_q <= i_dst;
					left_q <= i_words;
					o_wdata <= i_fill_val;
					state_q <= i_fill ? D_WR : D_RD;
				end
				D_RD: if (i_ack) begin
					o_wdata <= i_rdata;
					src_q <= src_q + 32'h4;
					state_q <= D_WR;
				end
				D_WR: if (i_ack) begin
					dst_q <= dst_q + 32'h4;
					left_q <= left_q - 16'h0001;
					if (left_q == 16'h0001) begin
						o_done <= 1'b1;
						state_q <= D_IDLE;
					end else begin
						state_q <= i_fill ? D_WR : D_RD;
					end
				end
				default: state_q <= D_IDLE;
			endcase
		end
	end
endmodule

// ---- rtl/sfab_fabric.sv ----
// System fabric: decoder, master arbiter, RAM banks and shared flash port
// Behaviour
// - Addresses 0x0000_0000 to 0x0003_FFFF go to the boot ROM.
// - Addresses 0x1000_0000 to 0x100F_FFFF go to the mapped flash path.
// - Addresses 0x2000_0000 to 0x2001_7FFF go to static RAM.
// - Addresses 0x3000_0000 to 0x3000_FFFF go to the link controller.
// - Addresses 0x4000_0000 to 0x4000_FFFF go to the first peripheral bridge.
// - Addresses 0x4001_0000 to 0x4001_1FFF go to GPIO.
// - Addresses 0x4001_F000 to 0x4001_FFFF go to system control.
// - Addresses 0x5000_0000 to 0x5000_FFFF go to the second peripheral bridge.
// - Addresses 0x6000_0000 to 0x6000_0FFF go to the one-time memory.
// - Addresses 0x7000_0000 to 0x7000_0FFF go to DMA registers.
// - Addresses 0x8000_0000 to 0x8000_0FFF go to the microphone interface.
// - DMA wins the bus over the processor when both request.
// - DMA copies memory blocks or fills them with a constant.
// - RAM is eight 16 KB banks, two kept for the link controller.
// - Each bank has its own power setting in each low-power state.
// - Flash serial clock never exceeds 32 MHz.
// - Three internal cores share the flash port.
// - One core does single-lane flash reads and writes via indirect address.
// - One core only shifts software-given bits in or out.
// - One core maps the flash onto the bus and runs the protocol itself.
// - The mapped path has a read-only cache that skips repeat transfers.
// - The flash port runs at its own slower rate, a quarter of the system clock.
`timescale 1ns/1ps
module sfab_fabric (
	input wire logic i_clk,
	input wire logic i_reset,
	input wire logic i_cpu_req,
	input wire logic [31:0] i_cpu_addr,
	input wire logic i_cpu_write,
	input wire logic [31:0] i_cpu_wdata,
	output logic o_cpu_ready,
	output logic o_cpu_err,
	output logic [31:0] o_cpu_rdata,
	input wire logic i_dma_go,
	input wire logic i_dma_fill,
	input wire logic [31:0] i_dma_src,
	input wire logic [31:0] i_dma_dst,
	input wire logic [15:0] i_dma_words,
	input wire logic [31:0] i_dma_fill_val,
	output logic o_dma_busy,
	output logic o_dma_done,
	output logic o_dma_err,
	output logic [9:0] o_slv_sel,
	output logic [31:0] o_slv_addr,
	output logic o_slv_write,
	output logic [31:0] o_slv_wdata,
	input wire logic i_slv_ready,
	input wire logic [31:0] i_slv_rdata,
	output logic [7:0] o_ram_bank_sel,
	input wire logic [1:0] i_lp_state,
	input wire logic [7:0] i_bank_keep_ret,
	input wire logic [7:0] i_bank_keep_hib,
	output logic [7:0] o_bank_power_on,
	input wire logic i_cache_en,
	input wire logic i_ind_go,
	input wire logic i_ind_write,
	input wire logic [23:0] i_ind_addr,
	input wire logic [7:0] i_ind_wdata,
	output logic o_ind_done,
	output logic [7:0] o_ind_rdata,
	input wire logic i_sh_go,
	input wire logic [5:0] i_sh_out_bits,
	input wire logic [31:0] i_sh_out_data,
	input wire logic [5:0] i_sh_in_bits,
	output logic o_sh_done,
	output logic [31:0] o_sh_in_data,
	output logic o_fl_sck,
	output logic o_fl_cs_n,
	output logic [3:0] o_fl_dq,
	output logic [3:0] o_fl_dq_oe_n,
	input wire logic [3:0] i_fl_dq
);
	typedef enum logic [2:0] {S_IDLE, S_DECODE, S_SLAVE, S_CACHE, S_FILL, S_WAIT} sfab_bus_e;
	typedef enum logic [1:0] {OWN_NONE, OWN_BRIDGE, OWN_INDIRECT, OWN_SHIFT} sfab_own_e;

	sfab_bus_e state_q;
	sfab_own_e owner_q;
	sfab_pkg::sfab_region_e region;
	logic gnt_dma_q;
	logic [31:0] addr_q, wdata_q;
	logic write_q;

	logic dma_req, dma_write, dma_ack_q;
	logic [31:0] dma_addr, dma_wdata, dma_rdata_q;
	logic dma_busy, dma_done;

	logic ind_pend_q, sh_pend_q, br_req_q;
	logic phy_start_q, phy_quad_q, phy_busy, phy_done;
	logic [5:0] phy_out_bits_q, phy_in_bits_q;
	logic [39:0] phy_out_q;
	logic [31:0] phy_in;

	logic [sfab_pkg::CACHE_IDX_W-1:0] cidx;
	logic [sfab_pkg::FL_ADDR_W-3-sfab_pkg::CACHE_IDX_W:0] ctag;
	logic [31:0] cache_data [sfab_pkg::CACHE_LINES];
	logic [sfab_pkg::FL_ADDR_W-3-sfab_pkg::CACHE_IDX_W:0] cache_tag [sfab_pkg::CACHE_LINES];
	logic [sfab_pkg::CACHE_LINES-1:0] cache_vld_q;
	logic cache_hit;

	// ==========================================
	// Address decode
	function automatic logic in_rng(input logic [31:0] a, input logic [31:0] lo, input logic [31:0] hi);
		in_rng = (a >= lo) && (a <= hi);
	endfunction

	always_comb begin
		region = sfab_pkg::REGION_NONE;
		if (addr_q <= sfab_pkg::ROM_HI) region = sfab_pkg::REGION_ROM;
		else if (in_rng(addr_q, sfab_pkg::FLASH_LO, sfab_pkg::FLASH_HI)) region = sfab_pkg::REGION_FLASH;
		else if (in_rng(addr_q, sfab_pkg::SRAM_LO, sfab_pkg::SRAM_HI)) region = sfab_pkg::REGION_SRAM;
		else if (in_rng(addr_q, sfab_pkg::LINK_LO, sfab_pkg::LINK_HI)) region = sfab_pkg::REGION_LINK;
		else if (in_rng(addr_q, sfab_pkg::PER0_LO, sfab_pkg::PER0_HI)) region = sfab_pkg::REGION_FIRST_PERIPH;
		else if (in_rng(addr_q, sfab_pkg::GPIO_LO, sfab_pkg::GPIO_HI)) region = sfab_pkg::REGION_GPIO;
		else if (in_rng(addr_q, sfab_pkg::SYSC_LO, sfab_pkg::SYSC_HI))
			region = sfab_pkg::REGION_SYSTEM_CONTROL_BLOCK;
		else if (in_rng(addr_q, sfab_pkg::PER1_LO, sfab_pkg::PER1_HI))
			region = sfab_pkg::REGION_SECOND_PERIPH;
		else if (in_rng(addr_q, sfab_pkg::OTP_LO, sfab_pkg::OTP_HI)) region = sfab_pkg::REGION_ONE_TIME_PROG;
		else if (in_rng(addr_q, sfab_pkg::DMA_LO, sfab_pkg::DMA_HI)) region = sfab_pkg::REGION_DMA;
		else if (in_rng(addr_q, sfab_pkg::MIC_LO, sfab_pkg::MIC_HI)) region = sfab_pkg::REGION_DIGITAL_MIC;
	end

	// ==========================================
	// Cache lookup
	assign cidx = addr_q[2 +: sfab_pkg::CACHE_IDX_W];
	assign ctag = addr_q[sfab_pkg::FL_ADDR_W-1:2+sfab_pkg::CACHE_IDX_W];
	assign cache_hit = i_cache_en && cache_vld_q[cidx] && (cache_tag[cidx] == ctag);

	// ==========================================
	// Master arbitration and transfer
	always_ff @(posedge i_clk) begin
		o_cpu_ready <= 1'b0;
		o_cpu_err <= 1'b0;
		dma_ack_q <= 1'b0;
		if (i_reset) begin
			state_q <= S_IDLE;
			gnt_dma_q <= 1'b0;
			addr_q <= '0;
			wdata_q <= '0;
			write_q <= 1'b0;
			o_slv_sel <= '0;
			o_slv_addr <= '0;
			o_slv_write <= 1'b0;
			o_slv_wdata <= '0;
			o_ram_bank_sel <= '0;
			o_cpu_rdata <= '0;
			o_dma_err <= 1'b0;
			dma_rdata_q <= '0;
			br_req_q <= 1'b0;
		end else begin
			case (state_q)
				S_IDLE: begin
					if (dma_req && !dma_ack_q) begin
						gnt_dma_q <= 1'b1;
						addr_q <= dma_addr;
						write_q <= dma_write;
						wdata_q <= dma_wdata;
						state_q <= S_DECODE;
					end else if (i_cpu_req && !o_cpu_ready && !dma_req) begin
						gnt_dma_q <= 1'b0;
						addr_q <= i_cpu_addr;
						write_q <= i_cpu_write;
						wdata_q <= i_cpu_wdata;
						state_q <= S_DECODE;
					end
				end
				S_DECODE: begin
					if (region == sfab_pkg::REGION_FLASH) begin
						state_q <= write_q ? S_WAIT : S_CACHE;
					end else if (region == sfab_pkg::REGION_NONE) begin
						state_q <= S_WAIT;
					end else begin
						o_slv_sel[region] <= 1'b1;
						o_slv_addr <= addr_q;
						o_slv_write <= write_q;
						o_slv_wdata <= wdata_q;
						if (region == sfab_pkg::REGION_SRAM)
							o_ram_bank_sel[addr_q[sfab_pkg::BANK_LSB +: sfab_pkg::BANK_W]] <= 1'b1;
						state_q <= S_SLAVE;
					end
				end
				S_SLAVE: if (i_slv_ready) begin
					o_slv_sel <= '0;
					o_ram_bank_sel <= '0;
					o_slv_write <= 1'b0;
					o_cpu_rdata <= i_slv_rdata;
					dma_rdata_q <= i_slv_rdata;
					o_cpu_ready <= !gnt_dma_q;
					dma_ack_q <= gnt_dma_q;
					state_q <= S_IDLE;
				end
				S_CACHE: begin
					if (cache_hit) begin
						o_cpu_rdata <= cache_data[cidx];
						dma_rdata_q <= cache_data[cidx];
						o_cpu_ready <= !gnt_dma_q;
						dma_ack_q <= gnt_dma_q;
						state_q <= S_IDLE;
					end else begin
						br_req_q <= 1'b1;
						state_q <= S_FILL;
					end
				end
				S_FILL: if (phy_done && owner_q == OWN_BRIDGE) begin
					br_req_q <= 1'b0;
					o_cpu_rdata <= phy_in;
					dma_rdata_q <= phy_in;
					o_cpu_ready <= !gnt_dma_q;
					dma_ack_q <= gnt_dma_q;
					state_q <= S_IDLE;
				end
				S_WAIT: begin
					// Error answer: unmapped space or write to the read-only bridge
					o_cpu_ready <= !gnt_dma_q;
					o_cpu_err <= !gnt_dma_q;
					o_dma_err <= o_dma_err | gnt_dma_q;
					dma_ack_q <= gnt_dma_q;
					state_q <= S_IDLE;
				end
				default: state_q <= S_IDLE;
			endcase
		end
	end

	// ==========================================
	// Cache fill
	always_ff @(posedge i_clk) begin
		if (i_reset || !i_cache_en) begin
			cache_vld_q <= '0;
		end else if (state_q == S_FILL && phy_done && owner_q == OWN_BRIDGE) begin
			cache_vld_q[cidx] <= 1'b1;
		end
	end

	always_ff @(posedge i_clk) begin
		if (state_q == S_FILL && phy_done && owner_q == OWN_BRIDGE) begin
			cache_data[cidx] <= phy_in;
			cache_tag[cidx] <= ctag;
		end
	end

	// ==========================================
	// RAM bank power, one setting per bank per low-power state, all on when active
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			o_bank_power_on <= '1;
		end else begin
			case (i_lp_state)
				sfab_pkg::LP_RETENTION: o_bank_power_on <= i_bank_keep_ret;
				sfab_pkg::LP_HIBERNATE: o_bank_power_on <= i_bank_keep_hib;
				default: o_bank_power_on <= '1;
			endcase
		end
	end

	// ==========================================
	// Flash port sharing
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			ind_pend_q <= 1'b0;
			sh_pend_q <= 1'b0;
		end else begin
			ind_pend_q <= i_ind_go | (ind_pend_q & ~(owner_q == OWN_INDIRECT));
			sh_pend_q <= i_sh_go | (sh_pend_q & ~(owner_q == OWN_SHIFT));
		end
	end

	always_ff @(posedge i_clk) begin
		phy_start_q <= 1'b0;
		o_ind_done <= 1'b0;
		o_sh_done <= 1'b0;
		if (i_reset) begin
			owner_q <= OWN_NONE;
			phy_quad_q <= 1'b0;
			phy_out_q <= '0;
			phy_out_bits_q <= '0;
			phy_in_bits_q <= '0;
			o_ind_rdata <= '0;
			o_sh_in_data <= '0;
		end else if (owner_q == OWN_NONE) begin
			if (br_req_q && state_q == S_FILL) begin
				owner_q <= OWN_BRIDGE;
				phy_start_q <= 1'b1;
				phy_quad_q <= 1'b1;
				phy_out_q <= {sfab_pkg::CMD_QREAD, 4'h0, addr_q[sfab_pkg::FL_ADDR_W-1:2], 2'b00, 8'h00};
				phy_out_bits_q <= sfab_pkg::BITS_CMD_ADDR;
				phy_in_bits_q <= sfab_pkg::BITS_WORD;
			end else if (ind_pend_q) begin
				owner_q <= OWN_INDIRECT;
				phy_start_q <= 1'b1;
				phy_quad_q <= 1'b0;
				phy_out_q <= {i_ind_write ? sfab_pkg::CMD_PROG : sfab_pkg::CMD_READ, i_ind_addr, i_ind_wdata};
				phy_out_bits_q <= i_ind_write ? sfab_pkg::BITS_CMD_ADDR + sfab_pkg::BITS_BYTE : sfab_pkg::BITS_CMD_ADDR;
				phy_in_bits_q <= i_ind_write ? 6'h00 : sfab_pkg::BITS_BYTE;
			end else if (sh_pend_q) begin
				owner_q <= OWN_SHIFT;
				phy_start_q <= 1'b1;
				phy_quad_q <= 1'b0;
				phy_out_q <= {i_sh_out_data, 8'h00};
				phy_out_bits_q <= i_sh_out_bits;
				phy_in_bits_q <= i_sh_in_bits;
			end
		end else if (phy_done) begin
			owner_q <= OWN_NONE;
			o_ind_done <= (owner_q == OWN_INDIRECT);
			o_sh_done <= (owner_q == OWN_SHIFT);
			if (owner_q == OWN_INDIRECT) o_ind_rdata <= phy_in[7:0];
			if (owner_q == OWN_SHIFT) o_sh_in_data <= phy_in;
		end
	end

	// ==========================================
	// Engines
	sfab_dma u_dma (
		.i_clk(i_clk),
		.i_reset(i_reset),
		.i_go(i_dma_go),
		.i_fill(i_dma_fill),
		.i_src(i_dma_src),
		.i_dst(i_dma_dst),
		.i_words(i_dma_words),
		.i_fill_val(i_dma_fill_val),
		.o_req(dma_req),
		.o_addr(dma_addr),
		.o_write(dma_write),
		.o_wdata(dma_wdata),
		.i_ack(dma_ack_q),
		.i_rdata(dma_rdata_q),
		.o_busy(dma_busy),
		.o_done(dma_done)
	);

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			o_dma_busy <= 1'b0;
			o_dma_done <= 1'b0;
		end else begin
			o_dma_busy <= dma_busy;
			o_dma_done <= dma_done;
		end
	end

	sfab_qspi_phy u_phy (
		.i_clk(i_clk),
		.i_reset(i_reset),
		.i_start(phy_start_q),
		.i_quad(phy_quad_q),
		.i_out_bits(phy_out_bits_q),
		.i_out_data(phy_out_q),
		.i_in_bits(phy_in_bits_q),
		.i_dq(i_fl_dq),
		.o_busy(phy_busy),
		.o_done(phy_done),
		.o_in_data(phy_in),
		.o_sck(o_fl_sck),
		.o_cs_n(o_fl_cs_n),
		.o_dq(o_fl_dq),
		.o_dq_oe_n(o_fl_dq_oe_n)
	);

endmodule

// ---- tb/sfab_flash_model.sv ----
// Flash partner: fixed read nibble inside frames, inverse when released
`timescale 1ns/1ps
module sfab_flash_model #(
	parameter logic [3:0] RD_NIB = 4'hF
) (
	input wire logic i_sck,
	input wire logic i_cs_n,
	output logic [3:0] o_dq
);
	initial o_dq = ~RD_NIB;
	// New data after each falling edge, ready before the sampling rise
	always @(negedge i_sck or posedge i_cs_n) begin
		o_dq <= i_cs_n ? ~RD_NIB : RD_NIB;
	end
endmodule

// ---- tb/sfab_fabric_assertions.sv ----
// Checker: decode ranges, bank power and flash clock timing
`timescale 1ns/1ps
module sfab_fabric_assertions (
	input wire logic i_clk,
	input wire logic i_reset,
	input wire logic [1:0] i_lp_state,
	input wire logic [7:0] i_bank_keep_ret,
	input wire logic o_cpu_ready,
	input wire logic o_cpu_err,
	input wire logic [9:0] o_slv_sel,
	input wire logic [31:0] o_slv_addr,
	input wire logic [7:0] o_ram_bank_sel,
	input wire logic [7:0] o_bank_power_on,
	input wire logic o_fl_sck,
	input wire logic o_dma_done,
	input wire logic o_sh_done
);
	default clocking @(posedge i_clk);
	endclocking
	default disable iff (i_reset);
	property p_err; o_cpu_err |-> o_cpu_ready; endproperty
	a_err: assert property (p_err) else $error("error without ready");
	property p_rom; o_slv_sel[0] |-> o_slv_addr <= sfab_pkg::ROM_HI; endproperty
	a_rom: assert property (p_rom) else $error("rom select off range");
	property p_sram; o_slv_sel[1] |-> o_slv_addr inside {[sfab_pkg::SRAM_LO:sfab_pkg::SRAM_HI]}; endproperty
	a_sram: assert property (p_sram) else $error("ram select off range");
	property p_gpio; o_slv_sel[4] |-> o_slv_addr inside {[sfab_pkg::GPIO_LO:sfab_pkg::GPIO_HI]}; endproperty
	a_gpio: assert property (p_gpio) else $error("gpio select off range");
	property p_sysc; o_slv_sel[5] |-> o_slv_addr inside {[sfab_pkg::SYSC_LO:sfab_pkg::SYSC_HI]}; endproperty
	a_sysc: assert property (p_sysc) else $error("sysctrl select off range");
	property p_bank; o_slv_sel[1] |-> o_ram_bank_sel == (8'h01 << o_slv_addr[16:14]); endproperty
	a_bank: assert property (p_bank) else $error("wrong ram bank");
	property p_pwr_act; i_lp_state == 2'h0 |=> o_bank_power_on == 8'hFF; endproperty
	a_pwr_act: assert property (p_pwr_act) else $error("bank off while active");
	property p_pwr_ret; i_lp_state == 2'h1 |=> o_bank_power_on == $past(i_bank_keep_ret); endproperty
	a_pwr_ret: assert property (p_pwr_ret) else $error("retention mask wrong");
	property p_sck_hi; $rose(o_fl_sck) |=> o_fl_sck; endproperty
	a_sck_hi: assert property (p_sck_hi) else $error("serial clock high too short");
	property p_sck_lo; $fell(o_fl_sck) |=> !o_fl_sck; endproperty
	a_sck_lo: assert property (p_sck_lo) else $error("serial clock low too short");
	c_err: cover property (o_cpu_err);
	c_dma: cover property (o_dma_done);
	c_sh: cover property (o_sh_done);
endmodule
bind sfab_fabric sfab_fabric_assertions u_sfab_fabric_assertions (.i_clk(i_clk), .i_reset(i_reset),
	.i_lp_state(i_lp_state), .i_bank_keep_ret(i_bank_keep_ret), .o_cpu_ready(o_cpu_ready),
	.o_cpu_err(o_cpu_err), .o_slv_sel(o_slv_sel), .o_slv_addr(o_slv_addr),
	.o_ram_bank_sel(o_ram_bank_sel), .o_bank_power_on(o_bank_power_on), .o_fl_sck(o_fl_sck),
	.o_dma_done(o_dma_done), .o_sh_done(o_sh_done));

// ---- tb/testbench.sv ----
// Testbench: decode, DMA, bank power and shared flash port
`timescale 1ns/1ps
module testbench;
	logic i_clk, i_reset, i_cpu_req, i_cpu_write, i_dma_go, i_dma_fill, i_slv_ready, i_cache_en;
	logic i_ind_go, i_ind_write, i_sh_go, o_cpu_ready, o_cpu_err, o_dma_busy, o_dma_done, o_dma_err;
	logic o_slv_write, o_ind_done, o_sh_done, o_fl_sck, o_fl_cs_n, err;
	logic [31:0] i_cpu_addr, i_cpu_wdata, o_cpu_rdata, i_dma_src, i_dma_dst, i_dma_fill_val, fv;
	logic [31:0] o_slv_addr, o_slv_wdata, i_slv_rdata, i_sh_out_data, o_sh_in_data, rng;
	logic [31:0] a_q[$], d_q[$], m_q[$];
	logic [15:0] i_dma_words;
	logic [9:0] o_slv_sel;
	logic [7:0] o_ram_bank_sel, i_bank_keep_ret, i_bank_keep_hib, o_bank_power_on, i_ind_wdata, o_ind_rdata;
	logic [5:0] i_sh_out_bits, i_sh_in_bits;
	logic [3:0] o_fl_dq, o_fl_dq_oe_n, i_fl_dq, fl_drv;
	logic [1:0] i_lp_state;
	logic [23:0] i_ind_addr;
	int n_fail, comparisons, n_done, n_ind, n_sh, lat, j;
	localparam logic [31:0] LO[10] = '{32'h0, sfab_pkg::SRAM_LO, sfab_pkg::LINK_LO, sfab_pkg::PER0_LO,
		sfab_pkg::GPIO_LO, sfab_pkg::SYSC_LO, sfab_pkg::PER1_LO, sfab_pkg::OTP_LO, sfab_pkg::DMA_LO, sfab_pkg::MIC_LO};
	localparam logic [31:0] HI[10] = '{sfab_pkg::ROM_HI, sfab_pkg::SRAM_HI, sfab_pkg::LINK_HI, sfab_pkg::PER0_HI,
		sfab_pkg::GPIO_HI, sfab_pkg::SYSC_HI, sfab_pkg::PER1_HI, sfab_pkg::OTP_HI, sfab_pkg::DMA_HI, sfab_pkg::MIC_HI};

	sfab_fabric u_sfab_fabric (.*);
	sfab_flash_model u_sfab_flash_model (.i_sck(o_fl_sck), .i_cs_n(o_fl_cs_n), .o_dq(fl_drv));
	assign i_fl_dq = (~o_fl_dq_oe_n & o_fl_dq) | (o_fl_dq_oe_n & fl_drv);

	initial begin
		i_clk = 1'b0;
		forever #5 i_clk = ~i_clk;
	end

	// ========
	// Slave responder and event counters
	always @(posedge i_clk) begin
		i_slv_ready <= |o_slv_sel && !i_slv_ready;
		i_slv_rdata <= o_slv_addr ^ 32'h5A5A_5A5A;
		if (|o_slv_sel && !i_slv_ready) begin
			a_q.push_back(o_slv_addr);
			d_q.push_back(o_slv_wdata);
			m_q.push_back({o_slv_write, 21'h0, o_slv_sel});
		end
		n_done += int'(o_dma_done === 1'b1);
		n_ind += int'(o_ind_done === 1'b1);
		n_sh += int'(o_sh_done === 1'b1);
	end

	// ========
	// Helpers
	function automatic logic [31:0] rnd();
		rng ^= rng << 13;
		rng ^= rng >> 17;
		rng ^= rng << 5;
		return rng;
	endfunction
	function automatic logic [9:0] exp_sel(input logic [31:0] a);
		exp_sel = '0;
		for (int k = 0; k < 10; k++)
			exp_sel[k] = a >= LO[k] && a <= HI[k];
	endfunction
	task chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task cpu(input logic [31:0] a, input logic wr);
		@(posedge i_clk);
		i_cpu_req <= 1'b1;
		i_cpu_addr <= a;
		i_cpu_write <= wr;
		i_cpu_wdata <= ~a;
		lat = 0;
		do begin
			@(negedge i_clk);
			lat++;
		end while (o_cpu_ready !== 1'b1 && lat < 400);
		err = o_cpu_err;
		@(posedge i_clk);
		i_cpu_req <= 1'b0;
		chk(32'(lat < 400), 32'h1);
	endtask
	task acc(input logic [31:0] a, input logic wr);
		logic [9:0] es;
		logic fl;
		es = exp_sel(a);
		fl = a >= sfab_pkg::FLASH_LO && a <= sfab_pkg::FLASH_HI;
		a_q.delete();
		d_q.delete();
		m_q.delete();
		cpu(a, wr);
		chk({31'h0, err}, {31'h0, es == '0 && !(fl && !wr)});
		chk(32'(a_q.size()), 32'(es != '0));
		if (es != '0) begin
			chk(m_q[0], {wr, 21'h0, es});
			chk(a_q[0], a);
			chk(wr ? d_q[0] : o_cpu_rdata, wr ? ~a : a ^ 32'h5A5A_5A5A);
		end
	endtask
	task dma(input logic fill, input logic [31:0] src, input logic [31:0] dst, input logic [15:0] n);
		j = n_done;
		a_q.delete();
		d_q.delete();
		m_q.delete();
		@(posedge i_clk);
		{i_dma_go, i_dma_fill, i_dma_src, i_dma_dst, i_dma_words} <= {1'b1, fill, src, dst, n};
		@(posedge i_clk);
		i_dma_go <= 1'b0;
	endtask
	task wrap_up();
		$display("comparisons %0d n_fail %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	initial begin
		#800000;
		n_fail++;
		wrap_up();
	end

	initial begin
		{i_cpu_req, i_cpu_write, i_dma_go, i_dma_fill, i_ind_go, i_ind_write, i_sh_go} = '0;
		{i_cpu_addr, i_cpu_wdata, i_dma_src, i_dma_dst, i_dma_fill_val, i_sh_out_data} = '0;
		{i_dma_words, i_bank_keep_ret, i_bank_keep_hib, i_ind_wdata, i_sh_out_bits, i_sh_in_bits} = '0;
		{i_lp_state, i_ind_addr} = '0;
		{i_reset, i_cache_en, rng} = {2'b11, 32'd73572};
		repeat (5) @(posedge i_clk);
		i_reset <= 1'b0;
		for (int k = 0; k < 10; k++) begin
			acc(LO[k], 1'b0);
			acc(HI[k], 1'b1);
			acc(HI[k] + 32'h1, 1'b0);
			acc(LO[k] - 32'h1, 1'b1);
		end
		repeat (60)
			acc(rnd() & 32'h7001_FFFF, rng[7]);
		$display("decode tests done");
		cpu(sfab_pkg::FLASH_LO + 32'h8, 1'b0);
		chk(o_cpu_rdata, 32'hFFFF_FFFF);
		cpu(sfab_pkg::FLASH_LO + 32'h8, 1'b0);
		chk(32'(lat <= 5), 32'h1);
		chk(o_cpu_rdata, 32'hFFFF_FFFF);
		i_cache_en <= 1'b0;
		cpu(sfab_pkg::FLASH_LO + 32'h8, 1'b0);
		chk(32'(lat > 10), 32'h1);
		i_cache_en <= 1'b1;
		acc(sfab_pkg::FLASH_LO, 1'b1);
		$display("flash bridge tests done");
		fv = rnd();
		i_dma_fill_val <= fv;
		dma(1'b1, 32'h0, sfab_pkg::SRAM_LO + 32'h100, 16'h4);
		cpu(sfab_pkg::GPIO_LO, 1'b0);
		for (int k = 0; k < 4; k++) begin
			chk(a_q[k], sfab_pkg::SRAM_LO + 32'h100 + 32'(4 * k));
			chk(d_q[k], fv);
		end
		chk(a_q[4], sfab_pkg::GPIO_LO);
		for (lat = 0; n_done == j && lat < 300; lat++)
			@(negedge i_clk);
		chk(32'(n_done - j), 32'h1);
		dma(1'b0, 32'h40, sfab_pkg::SRAM_LO, 16'h2);
		for (lat = 0; n_done == j && lat < 300; lat++)
			@(negedge i_clk);
		j = 0;
		foreach (m_q[k])
			if (m_q[k][31]) begin
				chk(d_q[k], (32'h40 + 32'(4 * j)) ^ 32'h5A5A_5A5A);
				j++;
			end
		chk(32'(j), 32'h2);
		chk({30'h0, o_dma_busy, o_dma_err}, 32'h0);
		$display("dma tests done");
		for (int s = 1; s < 3; s++) begin
			@(posedge i_clk);
			{i_lp_state, i_bank_keep_ret, i_bank_keep_hib} <= {2'(s), 16'(rnd())};
			repeat (3) @(posedge i_clk);
			chk(o_bank_power_on, s == 1 ? i_bank_keep_ret : i_bank_keep_hib);
		end
		i_lp_state <= 2'h0;
		repeat (3) @(posedge i_clk);
		chk(o_bank_power_on, 8'hFF);
		$display("bank power tests done");
		{i_ind_go, i_ind_addr, i_sh_go, i_sh_out_bits, i_sh_in_bits} <= {1'b1, 24'h100, 1'b1, 6'h8, 6'h8};
		i_sh_out_data <= 32'h9F00_0000;
		@(posedge i_clk);
		{i_ind_go, i_sh_go} <= 2'b00;
		for (lat = 0; (n_ind == 0 || n_sh == 0) && lat < 2000; lat++)
			@(negedge i_clk);
		chk(32'(n_ind), 32'h1);
		chk({24'h0, o_ind_rdata}, 32'hFF);
		chk(o_sh_in_data, 32'hFF);
		chk(32'(n_sh), 32'h1);
		chk({27'h0, o_fl_cs_n, o_fl_dq_oe_n}, 32'h1F);
		$display("flash core tests done");
		wrap_up();
	end
endmodule
